/* File: bench/handset_codec_select_bench.sv */
// Purpose : Self-checking bench for the handset codec select top
// Assumes : Frame shortened to 200 clocks, bit clock 20 MHz
// Notes   : Register traffic through a zero-wait bus master task
`timescale 1ns/100ps
`default_nettype none
`include "hcsel_defines.svh"

module handset_codec_select_bench;
   logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0]  pstrb = 4'hF;
   logic        pready, pslverr, err, mu_pd, a_pd, mux, comp, bclk, fsync, run = 1'b0, late = 1'b0;
   int          n_errors = 0, checks = 0, cyc = 0;

   hcsel_top #(.FRAME_CYC(200), .TOL_CYC(4), .CNT_W(16)) hcsel_top_inst (
      .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tel_bit_clk(bclk), .tel_frame_sync(fsync),
      .mu_codec_power_down(mu_pd), .a_codec_power_down(a_pd),
      .handset_mux_sel(mux), .codec_companded_mode(comp));
   hcsel_codec_model #(.BITS(40)) hcsel_codec_model_inst (
      .run(run), .late(late), .tel_bit_clk(bclk), .tel_frame_sync(fsync));

   always #5 clk = ~clk;

   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         conclude();
      end
   end

   // One bus transfer, held until pready is seen high
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s = 4'hF);
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(negedge clk);
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      // Power-up state
      chk({mu_pd, a_pd, mux, comp}, 32'h5);
      apb(`HCSEL_ADDR_STATUS, 1'b0, 32'h0);
      chk(rd[2:0], 32'h4);
      // Toggle the format both ways
      for (int i = 0; i < 3; i++) begin
         apb(`HCSEL_ADDR_CTRL, 1'b1, (i == 1) ? 32'hFFFF_FFFE : 32'h1);
         chk({mu_pd, a_pd, mux, comp}, (i == 1) ? 32'h5 : 32'hB);
         apb(`HCSEL_ADDR_CTRL, 1'b0, 32'h0);
         chk(rd, (i == 1) ? 32'h0 : 32'h1);
         apb(`HCSEL_ADDR_STATUS, 1'b0, 32'h0);
         chk(rd[2:0], (i == 1) ? 32'h4 : 32'h3);
      end
      // Ignored write lane, read-only frame counter and unmapped place
      apb(`HCSEL_ADDR_CTRL, 1'b1, 32'h0, 4'h0);
      apb(`HCSEL_ADDR_FRAMES, 1'b1, 32'hFFFF_FFFF);
      apb(`HCSEL_ADDR_FRAMES, 1'b0, 32'h0);
      chk(rd, 32'h0);
      chk(err, 32'h0);
      apb(12'h00C, 1'b1, 32'h0);
      chk({mu_pd, a_pd, err}, 32'h5);
      apb(12'h00C, 1'b0, 32'h0);
      chk(rd, 32'h0);
      chk(err, 32'h1);
      // Frame monitor: five good frames then one late
      run <= 1'b1;
      repeat (1000) @(posedge clk);
      apb(`HCSEL_ADDR_STATUS, 1'b0, 32'h0);
      chk({rd[31:8], rd[4:3]}, {16'd40, 8'd5, 2'b01});
      late <= 1'b1;
      repeat (250) @(posedge clk);
      late <= 1'b0;
      repeat (600) @(posedge clk);
      apb(`HCSEL_ADDR_STATUS, 1'b0, 32'h0);
      chk(rd[4], 32'h1);
      // Stop the clock, then clear the sticky flag
      run <= 1'b0;
      repeat (600) @(posedge clk);
      apb(`HCSEL_ADDR_STATUS, 1'b1, 32'h10);
      apb(`HCSEL_ADDR_STATUS, 1'b0, 32'h0);
      chk(rd[4:3], 32'h0);
      chk({mu_pd, a_pd, mux}, 32'h5);
      conclude();
   end
endmodule // handset_codec_select_bench
`default_nettype wire

/* File: bench/hcsel_codec_model.sv */
// Purpose : Telephony timing of the codec pair and switch
// Assumes : Frame length scaled down to match the design parameter
// Notes   : Clock stops low while run is low; late stretches frames to BITS + 10 bits while high
`timescale 1ns/100ps
`default_nettype none

module hcsel_codec_model #(
   parameter int BITS = 40 // Bit clocks per frame
) (
   input  wire logic run,
   input  wire logic late,
   output var  logic tel_bit_clk,
   output var  logic tel_frame_sync
);
   int cnt; // Bit position within the frame

   // Shared bit clock, phase unrelated to the system clock
   initial begin
      tel_bit_clk = 1'b0;
      #3.3;
      forever #25 tel_bit_clk = run ? ~tel_bit_clk : 1'b0;
   end

   // Frame sync between bit edges, one pulse per frame of 8-bit slots
   initial begin
      tel_frame_sync = 1'b0;
      cnt = 0;
      forever begin
         @(negedge tel_bit_clk);
         tel_frame_sync = (cnt == 0);
         cnt = (cnt + 1 >= (late ? BITS + 10 : BITS)) ? 0 : cnt + 1;
      end
   end
endmodule // hcsel_codec_model
`default_nettype wire

/* File: bench/hcsel_top_sva.sv */
// Purpose : Port-level checker for the handset codec select top
// Assumes : Zero-wait bus slave, one clock domain
// Notes   : Attached by bind at the foot of this file
`timescale 1ns/100ps
`default_nettype none
`include "hcsel_defines.svh"

module hcsel_top_sva (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        mu_codec_power_down,
   input wire logic        a_codec_power_down,
   input wire logic        handset_mux_sel,
   input wire logic        codec_companded_mode
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Access phase decodes
   wire logic acc     = psel && penable;
   wire logic wr_ctrl = acc && pwrite && paddr == `HCSEL_ADDR_CTRL && pstrb[0];
   wire logic rd_ctrl = acc && !pwrite && paddr == `HCSEL_ADDR_CTRL;
   wire logic rd_stat = acc && !pwrite && paddr == `HCSEL_ADDR_STATUS;

   a_one_active: assert property (mu_codec_power_down != a_codec_power_down)
      else $error("both codecs in the same power state");
   a_reset_mu: assert property ($rose(rst_n) |-> !mu_codec_power_down && a_codec_power_down)
      else $error("reset did not select mu-law");
   a_wr_decode: assert property (wr_ctrl |=> a_codec_power_down == !$past(pwdata[0]))
      else $error("select write not decoded");
   a_mux_follow: assert property (handset_mux_sel == mu_codec_power_down)
      else $error("mux select differs from decoded control");
   a_hold_sel: assert property (!wr_ctrl |=> $stable(a_codec_power_down) && $stable(handset_mux_sel))
      else $error("codec controls moved without a write");
   a_compand_on: assert property (codec_companded_mode)
      else $error("codecs left in linear mode");
   a_read_ctrl: assert property (rd_ctrl |-> prdata == {31'h0, mu_codec_power_down})
      else $error("control readback wrong");
   a_slot_count: assert property (rd_stat |-> prdata[15:8] == prdata[26:19]
      && prdata[2:1] == {a_codec_power_down, mu_codec_power_down})
      else $error("status slot count or states wrong");

   // Main scenarios
   c_to_alaw: cover property (wr_ctrl && pwdata[0]);
   c_to_mulaw: cover property (wr_ctrl && !pwdata[0]);
   c_locked: cover property (rd_stat && prdata[3]);
endmodule // hcsel_top_sva

bind hcsel_top hcsel_top_sva hcsel_top_sva_inst (
   .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
   .mu_codec_power_down(mu_codec_power_down), .a_codec_power_down(a_codec_power_down),
   .handset_mux_sel(handset_mux_sel), .codec_companded_mode(codec_companded_mode)
);
`default_nettype wire

/* File: core/hcsel_defines.svh */
// Purpose : Named constants for the handset codec select block
// Assumes : Included by bare name from files under core/
// Notes   : Definitions only, no logic
`ifndef HCSEL_DEFINES_SVH
`define HCSEL_DEFINES_SVH

// Register byte addresses on the APB bus
`define HCSEL_ADDR_CTRL        12'h000
`define HCSEL_ADDR_STATUS      12'h004
`define HCSEL_ADDR_FRAMES      12'h008
`define HCSEL_ADDR_W           12

// Control register fields
`define HCSEL_CTRL_FMT_BIT     0
`define HCSEL_FMT_MU_LAW       1'b0
`define HCSEL_FMT_A_LAW        1'b1
`define HCSEL_FMT_RESET        1'b0

// Status register fields
`define HCSEL_ST_FMT_BIT       0
`define HCSEL_ST_PD_MU_BIT     1
`define HCSEL_ST_PD_A_BIT      2
`define HCSEL_ST_LOCK_BIT      3
`define HCSEL_ST_RATE_ERR_BIT  4
`define HCSEL_ST_SLOTS_LSB     8
`define HCSEL_ST_SLOTS_W       8
`define HCSEL_ST_BITS_LSB      16
`define HCSEL_ST_BITS_W        16

// Sample format and frame timing
`define HCSEL_SLOT_BITS        8
`define HCSEL_SLOT_SHIFT       3
`define HCSEL_FRAME_NS         125000
`define HCSEL_CLK_NS           10
`define HCSEL_RATE_TOL_CYC     16
`define HCSEL_LOCK_GOOD        2'h2

`endif

/* File: core/hcsel_pkg.sv */
// Purpose : Types shared by the handset codec select block
// Assumes : Nothing beyond the constants header
// Notes   : Used by scoped names only, never imported
package hcsel_pkg;

   // Frame monitor states, Gray coded along idle-hunt-locked-error
   typedef enum logic [1:0] {
      HCSEL_FM_IDLE   = 2'h0,
      HCSEL_FM_HUNT   = 2'h1,
      HCSEL_FM_LOCKED = 2'h3,
      HCSEL_FM_ERR    = 2'h2
   } hcsel_fm_state_t;

endpackage

/* File: core/hcsel_sync.sv */
// Purpose : Three-stage input synchroniser with agreement filter
// Assumes : Inputs are asynchronous to clk
// Notes   : Output changes only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none

module hcsel_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   // Refuse a width the generate loop cannot build
   if (WIDTH < 1) begin : g_bad_width
      $error("hcsel_sync: WIDTH must be at least 1");
   end

   // One three-flop chain per bit
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic s1_q;                 // Metastable stage, read only by s2
      logic s2_q;                 // Second stage
      logic s3_q;                 // Third stage
      logic out_q;                // Filtered level

      // Shift chain
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
         end else begin
            s1_q <= async_in[i];
            s2_q <= s1_q;
            s3_q <= s2_q;
         end
      end

      // Take the new level once two and three agree
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            out_q <= 1'b0;
         end else if (s2_q == s3_q) begin
            out_q <= s3_q;
         end
      end

      assign sync_out[i] = out_q;
   end

endmodule // hcsel_sync

`default_nettype wire

/* File: core/hcsel_top.sv */
// Purpose : Handset codec select: picks the mu-law or A-law voice-band codec
// Assumes : APB slave, 100 MHz clk, telephony bit clock and frame sync as pins
// Notes   : Codecs take the telephony clock directly; this block watches it
//
// How it works
// RULE1: Exactly one codec format active at once
// RULE2: Reset selects mu-law, powers A-law down
// RULE3: Select bit decodes to complementary power-downs
// RULE4: Deselected codec stays powered down, output tristated; this block drives only the power-downs, no tristate control
// RULE5: A decoded control also drives analog mux
// RULE6: Codecs use 8-bit companded, not linear
// RULE7: Both codecs share master clock and sync
// RULE8: Streams carry 8-bit slots at 8 kHz
// RULE9: 0 is mu-law; outputs change together
`timescale 1ns/100ps
`default_nettype none
`include "hcsel_defines.svh"

module hcsel_top #(
   parameter int FRAME_CYC = `HCSEL_FRAME_NS / `HCSEL_CLK_NS, // Clocks per 8 kHz frame
   parameter int TOL_CYC   = `HCSEL_RATE_TOL_CYC,             // Allowed frame jitter
   parameter int CNT_W     = 16                                 // Frame length counter width
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Telephony timing pins
   input  wire logic        tel_bit_clk,
   input  wire logic        tel_frame_sync,
   // Codec controls
   output logic             mu_codec_power_down,
   output logic             a_codec_power_down,
   output logic             handset_mux_sel,
   output logic             codec_companded_mode
);

   // Refuse counts the counters cannot hold
   if (CNT_W < 8 || CNT_W > 16) begin : g_bad_cnt_w
      $error("hcsel_top: CNT_W must lie in 8..16");
   end
   if (FRAME_CYC + TOL_CYC >= (1 << CNT_W) || FRAME_CYC <= TOL_CYC) begin : g_bad_frame
      $error("hcsel_top: FRAME_CYC and TOL_CYC do not fit CNT_W");
   end

   localparam logic [CNT_W-1:0] FRAME_MIN = CNT_W'(FRAME_CYC - TOL_CYC); // Shortest good frame
   localparam logic [CNT_W-1:0] FRAME_MAX = CNT_W'(FRAME_CYC + TOL_CYC); // Longest good frame

   // ------------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------------
   logic rst_s1_q;                  // First release stage
   logic rst_s2_q;                  // Released reset used everywhere
   logic rst_int_n;                 // Internal active-low reset

   // Assert at once, release after two edges
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   assign rst_int_n = rst_s2_q;

   // ------------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------------
   wire       setup_ph  = psel & ~penable;                       // Setup phase
   wire       access_ph = psel & penable;                        // Access phase
   wire       hit_ctrl  = (paddr == `HCSEL_ADDR_CTRL);           // Control register
   wire       hit_stat  = (paddr == `HCSEL_ADDR_STATUS);         // Status register
   wire       hit_frm   = (paddr == `HCSEL_ADDR_FRAMES);         // Frame count register
   wire       hit_any   = hit_ctrl | hit_stat | hit_frm;         // Mapped address
   wire       wr_ctrl   = access_ph & pwrite & hit_ctrl & pstrb[0]; // Select bit write

   // Zero-wait slave; unmapped addresses answer with an error
   // Read data is registered in the setup phase, so no wait state is needed
   assign pready  = 1'b1;
   assign pslverr = access_ph & ~hit_any;

   // ------------------------------------------------------------------
   // Format select and codec controls
   // ------------------------------------------------------------------
   logic fmt_q;                     // 0 mu-law, 1 A-law
   logic fmt_d;                     // Next format
   logic pd_mu_q;                   // Mu-law codec power-down
   logic pd_a_q;                    // A-law codec power-down
   logic mux_q;                     // Analog mux select
   logic comp_q;                    // Companded mode strap

   // Software write takes the new format, else hold
   assign fmt_d = wr_ctrl ? pwdata[`HCSEL_CTRL_FMT_BIT] : fmt_q; // [RULE9]

   // Format register with mu-law reset value
   always_ff @(posedge clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         fmt_q <= `HCSEL_FMT_RESET; // [RULE2]
      end else begin
         fmt_q <= fmt_d;
      end
   end

   // Power-downs and mux follow the next format on the same edge
   always_ff @(posedge clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         pd_mu_q <= 1'b0;           // [RULE2]
         pd_a_q  <= 1'b1;           // [RULE2] [RULE4]
         mux_q   <= 1'b0;
      end else begin
         pd_mu_q <= (fmt_d == `HCSEL_FMT_A_LAW);  // [RULE3] [RULE9]
         pd_a_q  <= (fmt_d == `HCSEL_FMT_MU_LAW); // [RULE3] [RULE4] [RULE1]
         mux_q   <= (fmt_d == `HCSEL_FMT_A_LAW);  // [RULE5] [RULE9]
      end
   end

   // Companded 8-bit mode held on in reset and on every edge after it
   // Kept in a flop so the strap pin never glitches out of a gate
   always_ff @(posedge clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         comp_q <= 1'b1;            // [RULE6]
      end else begin
         comp_q <= 1'b1;            // [RULE6]
      end
   end

   assign mu_codec_power_down  = pd_mu_q;
   assign a_codec_power_down   = pd_a_q;
   assign handset_mux_sel      = mux_q;  // [RULE5]
   assign codec_companded_mode = comp_q;

   // ------------------------------------------------------------------
   // Telephony timing watch
   // ------------------------------------------------------------------
   logic [1:0] tel_sync;            // Synchronised bit clock and frame sync
   logic       bclk_prev_q;         // Bit clock last cycle
   logic       fs_prev_q;           // Frame sync last cycle

   // Both pins arrive from the telephony clock domain
   // A raw pin read by several flops could split on one edge; sync it once
   hcsel_sync #(
      .WIDTH    (2)
   ) hcsel_sync_inst (
      .clk      (clk),
      .rst_n    (rst_int_n),
      .async_in ({tel_frame_sync, tel_bit_clk}),
      .sync_out (tel_sync)
   );

   // Edge history
   always_ff @(posedge clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         bclk_prev_q <= 1'b0;
         fs_prev_q   <= 1'b0;
      end else begin
         bclk_prev_q <= tel_sync[0];
         fs_prev_q   <= tel_sync[1];
      end
   end

   wire bclk_rise = tel_sync[0] & ~bclk_prev_q;  // Bit clock edge
   wire fs_rise   = tel_sync[1] & ~fs_prev_q;    // Frame start, shared by both codecs [RULE7]

   logic [CNT_W-1:0] cyc_q;         // Clocks since last frame start
   logic [15:0]      bits_q;        // Bit clocks in current frame
   logic [15:0]      bits_last_q;   // Bit clocks in last frame
   logic [15:0]      frames_q;      // Frames seen, wraps
   logic [1:0]       good_q;        // Good frames in a row
   logic             rate_err_q;    // Sticky frame rate error

   hcsel_pkg::hcsel_fm_state_t fm_q; // Monitor state
   hcsel_pkg::hcsel_fm_state_t fm_d; // Next monitor state

   wire frame_ok  = (cyc_q >= FRAME_MIN) && (cyc_q <= FRAME_MAX); // 8 kHz frame [RULE8]
   wire frame_late = (cyc_q > FRAME_MAX);                         // Sync stopped
   wire frame_bad = (fs_rise & ~frame_ok) | frame_late;          // Rate fault
   wire locked    = (fm_q == hcsel_pkg::HCSEL_FM_LOCKED);        // Stream locked

   // Frame length counter, saturates once late
   always_ff @(posedge clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         cyc_q <= '0;
      end else if (fs_rise) begin
         cyc_q <= CNT_W'(1);
      end else if (!frame_late) begin
         cyc_q <= cyc_q + CNT_W'(1);
      end
   end

   // Bit clocks per frame, captured at each frame start
   // Saturates so a runaway bit clock cannot wrap into a plausible count
   always_ff @(posedge clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         bits_q      <= '0;
         bits_last_q <= '0;
      end else if (fs_rise) begin
         bits_q      <= {15'h0000, bclk_rise};
         bits_last_q <= bits_q;
      end else if (bclk_rise && bits_q != 16'hFFFF) begin
         bits_q      <= bits_q + 16'h0001;
      end
   end

   // Frame count and good-frame run
   always_ff @(posedge clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         frames_q <= '0;
         good_q   <= '0;
      end else if (fs_rise) begin
         frames_q <= frames_q + 16'h0001;
         good_q   <= frame_ok ? ((good_q == `HCSEL_LOCK_GOOD) ? good_q : good_q + 2'h1) : 2'h0;
      end else if (frame_late) begin
         good_q   <= 2'h0;
      end
   end

   // Monitor next state
   always_comb begin
      fm_d = fm_q;
      unique case (fm_q)
         hcsel_pkg::HCSEL_FM_IDLE: begin
            if (fs_rise) begin
               fm_d = hcsel_pkg::HCSEL_FM_HUNT;
            end
         end
         hcsel_pkg::HCSEL_FM_HUNT: begin
            if (frame_late) begin
               fm_d = hcsel_pkg::HCSEL_FM_IDLE;
            end else if (fs_rise && frame_ok && good_q == `HCSEL_LOCK_GOOD - 2'h1) begin
               fm_d = hcsel_pkg::HCSEL_FM_LOCKED; // [RULE8]
            end
         end
         hcsel_pkg::HCSEL_FM_LOCKED: begin
            if (frame_bad) begin
               fm_d = hcsel_pkg::HCSEL_FM_ERR;
            end
         end
         hcsel_pkg::HCSEL_FM_ERR: begin
            fm_d = frame_late ? hcsel_pkg::HCSEL_FM_IDLE : hcsel_pkg::HCSEL_FM_HUNT;
         end
      endcase
   end

   // Monitor state and sticky error; a fault wins over a clear
   // Software clears by writing one to the error bit of the status word
   // Faults count only while locked, so hunting after start-up stays quiet
   always_ff @(posedge clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         fm_q       <= hcsel_pkg::HCSEL_FM_IDLE;
         rate_err_q <= 1'b0;
      end else begin
         fm_q       <= fm_d;
         if (locked && frame_bad) begin
            rate_err_q <= 1'b1;
         end else if (access_ph && pwrite && hit_stat && pstrb[0]
                      && pwdata[`HCSEL_ST_RATE_ERR_BIT]) begin
            rate_err_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------------
   wire [15:0] slots  = bits_last_q >> `HCSEL_SLOT_SHIFT; // 8-bit slots per frame [RULE8]
   wire [31:0] st_word = {bits_last_q,
                          slots[`HCSEL_ST_SLOTS_W-1:0],
                          3'h0,
                          rate_err_q,
                          locked,
                          pd_a_q,
                          pd_mu_q,
                          fmt_q};
   wire [31:0] rd_mux = hit_ctrl ? {31'h00000000, fmt_q} :
                        hit_stat ? st_word :
                        hit_frm  ? {16'h0000, frames_q} : 32'h00000000;

   logic [31:0] prdata_q;           // Read data loaded in setup phase

   // Capture read data one cycle ahead of the access phase
   always_ff @(posedge clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         prdata_q <= '0;
      end else if (setup_ph && !pwrite) begin
         prdata_q <= rd_mux;
      end
   end
   assign prdata = prdata_q;

endmodule // hcsel_top

`default_nettype wire
